// ==== design/bus_hold_consts.vh ====
// Constants for the primary bus hold arbiter.
// Included by the arbiter only; its request synchroniser does not include it.
`ifndef BUS_HOLD_CONSTS_VH
`define BUS_HOLD_CONSTS_VH

// Wait states loaded at reset
`define RESET_WAIT_COUNT     3'h7
`define WAIT_COUNT_WIDTH     3
// Wait counter end point and step
`define WAIT_ZERO            3'h0
`define WAIT_STEP            3'h1
// Extra cycles of least request width
`define HOLD_WIDTH_EXTRA     4'h3
// Longest grant delay when request held through reset
`define RESET_GRANT_CYCLES   4'h9
`define CYCLE_COUNT_WIDTH    4

// Arbiter states
`define ST_IDLE              2'h0
`define ST_DRAIN             2'h1
`define ST_HELD              2'h2
`define ST_RELEASE           2'h3

`endif

// ==== design/hold_req_sync.v ====
// Three-stage synchroniser for the active-low bus release request.
// Assumes the request comes from another clock domain.
`timescale 1ns/1ps
module hold_req_sync (
	// Clock and reset
	input  wire i_sys_clk,
	input  wire i_rst_n,
	// Raw pin and cleaned level
	input  wire i_req_n,
	output reg  o_req_n
);
	reg meta_r;
	reg s2_r;
	reg s3_r;

	// Second and third stages must agree before a change counts
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r  <= 1'b1;
			s2_r    <= 1'b1;
			s3_r    <= 1'b1;
			o_req_n <= 1'b1;
		end else begin
			meta_r <= i_req_n;
			s2_r   <= meta_r;
			s3_r   <= s2_r;
			if (s2_r == s3_r)
				o_req_n <= s3_r;
		end
	end
endmodule // hold_req_sync

// ==== design/primary_bus_hold_arbiter.v ====
// Primary bus hold arbiter: hands the external bus to another master.
// Assumes i_sys_clk stands for the falling edge of the phase one clock,
// and that the core presents one access at a time on i_core_* ports.
//
// What this block does
// - Request synchronised; late setup may slip cycle
// - Lockout bit ends hold, ignores requests
// - No new bus access once request seen; cycle in flight ends
// - First write posted; stall on second
// - Request captured one cycle before cycle end
// - Grant low until one cycle after release
// - Bus outputs high impedance while granted
// - Request during reset: grant within nine
// - Reset loads seven software wait states
`timescale 1ns/1ps
`include "bus_hold_consts.vh"
module primary_bus_hold_arbiter #(
	parameter ADDR_W = 24,
	parameter DATA_W = 32
) (
	// Clock and reset
	input  wire              i_sys_clk,
	input  wire              i_reset_n,
	// External master handshake
	input  wire              i_bus_release_req_n,
	output reg               o_bus_release_grant_n,
	// Control from the bus control register
	input  wire              i_hold_lockout,
	input  wire              i_wait_load,
	input  wire [2:0]        i_wait_value,
	output reg  [2:0]        o_programmed_wait_count,
	// Core access request
	input  wire              i_core_req,
	input  wire              i_core_write,
	input  wire [ADDR_W-1:0] i_core_addr,
	input  wire [DATA_W-1:0] i_core_wdata,
	output reg               o_core_stall,
	output reg               o_core_done,
	// External bus pins
	output reg               o_external_access_strobe_n,
	output reg               o_rw,
	output reg  [ADDR_W-1:0] o_addr,
	output reg  [DATA_W-1:0] o_data,
	output reg               o_bus_oe,
	output reg               o_data_oe
);
	reg        rst_s1_r;
	reg        rst_n_r;
	wire       req_n;
	reg  [1:0] state_r;
	reg  [1:0] state_nxt;
	reg        busy_r;
	reg  [2:0] wait_r;
	reg        post_r;
	reg [ADDR_W-1:0] post_addr_r;
	reg [DATA_W-1:0] post_data_r;
	reg        hold_want;
	reg        cyc_last;

	// Arbiter states
	localparam [1:0] S_IDLE    = `ST_IDLE;
	localparam [1:0] S_DRAIN   = `ST_DRAIN;
	localparam [1:0] S_HELD    = `ST_HELD;
	localparam [1:0] S_RELEASE = `ST_RELEASE;

	// State that owns the grant and floats the bus
	function is_held;
		input [1:0] st;
		is_held = (st == S_HELD);
	endfunction

	// Last wait cycle of an access in flight
	function last_wait;
		input                         busy;
		input [`WAIT_COUNT_WIDTH-1:0] cnt;
		last_wait = busy && (cnt == `WAIT_ZERO);
	endfunction

	// No fresh access while hold pends or a write waits
	function bus_taken;
		input [1:0] st;
		input       busy;
		input       posted;
		bus_taken = (st != S_IDLE) || busy || posted;
	endfunction

	// Reset release through two flops
	always @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	hold_req_sync u_req_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (rst_n_r),
		.i_req_n   (i_bus_release_req_n),
		.o_req_n   (req_n)
	);

	always @* begin
		hold_want = !req_n && !i_hold_lockout;
		cyc_last  = last_wait(busy_r, wait_r);
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (hold_want)
					state_nxt = S_DRAIN;
			end
			S_DRAIN: begin
				if (!hold_want && !busy_r)
					state_nxt = S_IDLE;
				else if (!busy_r || cyc_last)
					state_nxt = hold_want ? S_HELD : S_IDLE;
			end
			S_HELD: begin
				if (!hold_want)
					state_nxt = S_RELEASE;
			end
			S_RELEASE: begin
				// One quiet cycle before the bus is reused
				state_nxt = S_IDLE;
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	// Bus cycle engine and hold control
	always @(posedge i_sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r                    <= S_IDLE;
			busy_r                     <= 1'b0;
			wait_r                     <= `WAIT_ZERO;
			o_programmed_wait_count    <= `RESET_WAIT_COUNT;
			post_r                     <= 1'b0;
			post_addr_r                <= {ADDR_W{1'b0}};
			post_data_r                <= {DATA_W{1'b0}};
			o_bus_release_grant_n      <= 1'b1;
			o_core_stall               <= 1'b0;
			o_core_done                <= 1'b0;
			o_external_access_strobe_n <= 1'b1;
			o_rw                       <= 1'b1;
			o_addr                     <= {ADDR_W{1'b0}};
			o_data                     <= {DATA_W{1'b0}};
			o_bus_oe                   <= 1'b1;
			o_data_oe                  <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			o_core_done <= 1'b0;
			if (i_wait_load)
				o_programmed_wait_count <= i_wait_value;
			o_bus_release_grant_n <= !is_held(state_nxt);
			o_bus_oe <= !is_held(state_nxt);
			if (busy_r) begin
				if (cyc_last) begin
					busy_r                     <= 1'b0;
					o_external_access_strobe_n <= 1'b1;
					o_rw                       <= 1'b1;
					o_data_oe                  <= 1'b0;
				end else begin
					wait_r <= wait_r - `WAIT_STEP;
				end
			end else if (state_nxt == S_IDLE && state_r != S_HELD && post_r) begin
				// Posted write goes out once hold ends
				busy_r                     <= 1'b1;
				wait_r                     <= o_programmed_wait_count;
				post_r                     <= 1'b0;
				o_external_access_strobe_n <= 1'b0;
				o_rw                       <= 1'b0;
				o_addr                     <= post_addr_r;
				o_data                     <= post_data_r;
				o_data_oe                  <= 1'b1;
			end
			if (i_core_req && !o_core_done) begin
				if (bus_taken(state_nxt, busy_r, post_r)) begin
					if (i_core_write && !post_r) begin
						post_r       <= 1'b1;
						post_addr_r  <= i_core_addr;
						post_data_r  <= i_core_wdata;
						o_core_done  <= 1'b1;
						o_core_stall <= 1'b0;
					end else begin
						o_core_stall <= 1'b1;
					end
				end else if (!busy_r) begin
					busy_r                     <= 1'b1;
					wait_r                     <= o_programmed_wait_count;
					o_external_access_strobe_n <= 1'b0;
					o_rw                       <= !i_core_write;
					o_addr                     <= i_core_addr;
					o_data                     <= i_core_wdata;
					o_data_oe                  <= i_core_write;
					o_core_done                <= 1'b1;
					o_core_stall               <= 1'b0;
				end
			end else begin
				o_core_stall <= 1'b0;
			end
		end
	end
endmodule // primary_bus_hold_arbiter

// ==== verif/bus_master_model.sv ====
// External master: asks for the bus, holds it, gives it back.
// Request idles high, as with a pull-up.
`timescale 1ns/1ps
module bus_master_model (
	input  wire       i_clk,
	input  wire       i_go,
	input  wire [7:0] i_len,
	input  wire       i_grant_n,
	output reg        o_req_n
);
	integer n, t;
	initial o_req_n = 1'b1;
	always begin
		@(posedge i_clk);
		if (i_go) begin
			#1 o_req_n = 1'b0;
			n = 0;
			t = 0;
			while ((n < i_len || t < 10) && t < 40) begin
				@(posedge i_clk);
				#1 t = t + 1;
				if (!i_grant_n) n = n + 1;
			end
			o_req_n = 1'b1;
		end
	end
endmodule // bus_master_model

// ==== verif/primary_bus_hold_arbiter_assertions.sv ====
// Checker on the hold arbiter ports.
// Bound from the bench top.
`timescale 1ns/1ps
module primary_bus_hold_arbiter_assertions (
	input wire logic       i_sys_clk,
	input wire logic       i_reset_n,
	input wire logic       i_bus_release_req_n,
	input wire logic       i_hold_lockout,
	input wire logic       o_bus_release_grant_n,
	input wire logic       o_external_access_strobe_n,
	input wire logic [2:0] o_programmed_wait_count,
	input wire logic       o_bus_oe,
	input wire logic       o_data_oe
);
	wire g = o_bus_release_grant_n;
	wire r = i_bus_release_req_n;
	wire s = o_external_access_strobe_n;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_free; (!i_hold_lockout)[*3]; endsequence
	sequence s_cyc; (!s)[*8] ##1 s; endsequence
	property p_off; !g |-> !o_bus_oe && !o_data_oe; endproperty
	a_off: assert property (p_off) else $error("bus driven");
	property p_quiet; !g |-> s; endproperty
	a_quiet: assert property (p_quiet) else $error("strobe in hold");
	property p_cause; $fell(g) |-> !$past(r, 3); endproperty
	a_cause: assert property (p_cause) else $error("grant unasked");
	property p_idle; $fell(g) |-> s; endproperty
	a_idle: assert property (p_idle) else $error("cycle cut");
	property p_keep; s_free ##0 (!g && !r) |=> !g; endproperty
	a_keep: assert property (p_keep) else $error("grant lost");
	property p_end; $rose(r) |-> ##[1:8] g; endproperty
	a_end: assert property (p_end) else $error("grant stuck");
	property p_lock; i_hold_lockout[*4] |-> g; endproperty
	a_lock: assert property (p_lock) else $error("grant locked");
	property p_len; $fell(s) && o_programmed_wait_count == 3'h7 |-> s_cyc; endproperty
	a_len: assert property (p_len) else $error("strobe width");
endmodule // primary_bus_hold_arbiter_assertions

// ==== verif/primary_bus_hold_arbiter_tb_top.sv ====
// Bench for the hold arbiter with a master model.
// Needs design, model and checker compiled first.
`timescale 1ns/1ps
module primary_bus_hold_arbiter_tb_top;
	reg        clk = 1'b0, rst_n = 1'b0, go = 1'b1, lk = 1'b0;
	reg        ld = 1'b0, cr = 1'b0, cw = 1'b0;
	reg  [2:0] wv = 3'h0;
	reg  [7:0] len = 8'h02;
	wire       rq_n, g_n, stl, dn, s_n, rw, boe;
	wire [2:0] wc;
	wire [23:0] ad;
	wire [31:0] dt;
	wire       doe;
	integer    err_total = 0, check_count = 0, k;
	always #50 clk = ~clk;
	bus_master_model m (.i_clk(clk), .i_go(go), .i_len(len), .i_grant_n(g_n), .o_req_n(rq_n));
	primary_bus_hold_arbiter uut (.i_sys_clk(clk), .i_reset_n(rst_n),
		.i_bus_release_req_n(rq_n), .o_bus_release_grant_n(g_n), .i_hold_lockout(lk),
		.i_wait_load(ld), .i_wait_value(wv), .o_programmed_wait_count(wc),
		.i_core_req(cr), .i_core_write(cw), .i_core_addr(24'h00A5C3),
		.i_core_wdata(32'h5A5AF00F), .o_core_stall(stl), .o_core_done(dn),
		.o_external_access_strobe_n(s_n), .o_rw(rw), .o_addr(ad), .o_data(dt),
		.o_bus_oe(boe), .o_data_oe(doe));
	task tk(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task ck(input logic [31:0] a, input logic [31:0] b);
		check_count++;
		if (a !== b) begin
			err_total++;
			$display("FAIL %0t %h %h", $time, a, b);
		end
	endtask
	task wg(input logic v);
		for (k = 0; g_n !== v && k < 60; k++) tk(1);
		ck(g_n, v);
	endtask
	task wd;
		for (k = 0; dn !== 1'b1 && k < 60; k++) tk(1);
		ck(dn, 1);
		cr = 1'b0;
	endtask
	task req;
		go = 1'b1;
		tk(1);
		go = 1'b0;
	endtask
	task t_reset;
		tk(2);
		rst_n = 1'b1;
		go = 1'b0;
		wg(0);
		ck(k <= 9, 1);
		ck(wc, 3'h7);
		ck(boe, 0);
		wg(1);
		ck(boe, 1);
	endtask
	task t_read;
		cr = 1'b1;
		wd;
		ck({s_n, rw}, 2'h1);
		len = 8'h0C;
		req;
		wg(0);
		ck({k >= 7, s_n}, 2'h3);
		cr = 1'b1;
		tk(2);
		ck(stl, 1);
		wd;
	endtask
	task t_write;
		ld = 1'b1;
		tk(1);
		ld = 1'b0;
		tk(1);
		ck(wc, 3'h0);
		len = 8'h14;
		req;
		wg(0);
		{cr, cw} = 2'h3;
		wd;
		ck({k < 4, s_n}, 2'h3);
		tk(1);
		cr = 1'b1;
		tk(3);
		ck(stl, 1);
		wd;
		// Posted write must reach the bus once hold ends
		for (k = 0; s_n !== 1'b0 && k < 20; k++) tk(1);
		ck({rw, doe}, 2'h1);
		ck(ad, 24'h00A5C3);
		ck(dt, 32'h5A5AF00F);
	endtask
	task t_lock;
		len = 8'h28;
		req;
		wg(0);
		lk = 1'b1;
		wg(1);
		ck(k < 5, 1);
		tk(8);
		ck({g_n, rq_n}, 2'h2);
		lk = 1'b0;
		tk(45);
		ck(g_n, 1);
	endtask
	task give_verdict;
		if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		t_reset;
		t_read;
		t_write;
		t_lock;
		give_verdict;
	end
	// Tests take about 14 us; limit leaves wide margin
	initial begin
		#100000;
		err_total++;
		give_verdict;
	end
endmodule // primary_bus_hold_arbiter_tb_top
bind primary_bus_hold_arbiter primary_bus_hold_arbiter_assertions u_chk (.i_sys_clk,
	.i_reset_n, .i_bus_release_req_n, .i_hold_lockout, .o_bus_release_grant_n,
	.o_external_access_strobe_n, .o_programmed_wait_count, .o_bus_oe, .o_data_oe);
